// file: pkg/dbgev_defines.vh
// constants of the debug event recorder: offsets, fields, reset values
`ifndef DBGEV_DEFINES_VH
`define DBGEV_DEFINES_VH

// register byte offsets
`define DBGEV_OFF_CTRL 8'h00
`define DBGEV_OFF_STAT 8'h04
`define DBGEV_OFF_EXT 8'h08
`define DBGEV_OFF_SAVE 8'h0C
`define DBGEV_OFF_FETCH 8'h10

// dbg_control0 fields
`define DBGEV_C_EXT_HALT 0
`define DBGEV_C_INT_MODE 1
`define DBGEV_C_INSTR_DONE_EVT_EN 2
`define DBGEV_C_IRQ_TAKEN_EVT_EN 3
`define DBGEV_C_RET_EN 4
`define DBGEV_CTRL_W 5
`define DBGEV_CTRL_RST 5'h00

// status fields, shared by internal and external status
`define DBGEV_S_INSTR_DONE 0
`define DBGEV_S_IRQ_TAKEN 1
`define DBGEV_S_IRQ_EXIT 2
`define DBGEV_S_UNCOND 3
`define DBGEV_S_IMPRECISE 4
`define DBGEV_STAT_W 5
`define DBGEV_STAT_RST 5'h00

`endif

// file: logic/dbgev_recorder.v
// debug event detection and recording with an apb register slave
//
// Notes on behaviour
// [RULE1] completion event when enabled and instruction retires
// [RULE2] no completion for suppressed or self-saving instructions
// [RULE3] os call completes; debug save points to handler
// [RULE4] external mode: record, halt, fetch next instruction
// [RULE5] internal mode: completion only with irq allow
// [RULE6] mtmsr uses its new irq allow value
// [RULE7] control update by mtspr applies to itself
// [RULE8] return uses irq allow before it executes
// [RULE9] internal completion raises irq, saves next address
// [RULE10] irq taken: enabled, non-debug/critical/machine-check only
// [RULE11] external mode irq taken: halt at handler
// [RULE12] internal, allow set: irq, save handler address
// [RULE13] allow clear: conditional record, set imprecise
// [RULE14] delayed irq saves address after enabling instruction
// [RULE15] external status ignores irq allow bit
// [RULE16] return event when enabled, no higher exception
// [RULE17] external mode return: suppress, halt at return
// [RULE18] internal, allow set: irq, save return address
// [RULE19] return checks old allow; clear sets imprecise
// [RULE20] unconditional input rising edge in either mode
// [RULE21] unconditional event recorded regardless of allow
// [RULE22] external mode unconditional: halt, fetch next
// [RULE23] internal unconditional sets imprecise; irq if allowed
`timescale 1ns/1ps
`include "dbgev_defines.vh"
`default_nettype none

module dbgev_recorder #(
   parameter ADDR_W = 32
) (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // retiring instruction from the pipeline
   input wire retire_valid,
   input wire retire_suppressed,
   input wire retire_saves_own_pc,
   input wire retire_is_os_call,
   input wire [ADDR_W-1:0] os_call_handler_addr,
   input wire [ADDR_W-1:0] retire_next_pc,
   input wire retire_is_mtmsr,
   input wire retire_ctl_wr,
   input wire [`DBGEV_CTRL_W-1:0] retire_ctl_data,
   // machine_state_reg allow bit before and after the instruction
   input wire dbg_irq_allow,
   input wire dbg_irq_allow_after,
   // operation type permits imprecise recording
   input wire op_records_imprecise,
   // non-critical interrupt taken
   input wire irq_taken_valid,
   input wire irq_is_noncrit,
   input wire [ADDR_W-1:0] irq_handler_addr,
   // return-from-interrupt attempt
   input wire rfi_valid,
   input wire rfi_higher_exc,
   input wire [ADDR_W-1:0] rfi_pc,
   // external debug controller
   input wire unconditional_evt_input,
   // results
   output reg dbg_irq,
   output reg [ADDR_W-1:0] dbg_save_pc,
   output reg halt_req,
   output reg [ADDR_W-1:0] next_fetch_addr,
   output reg suppress_rfi,
   output reg [`DBGEV_CTRL_W-1:0] dbg_control0,
   output reg [`DBGEV_STAT_W-1:0] dbg_event_status,
   output reg [`DBGEV_STAT_W-1:0] ext_dbg_event_status
);

   // ==========================================================
   // address decode
   // ==========================================================
   function [2:0] dec;
      input [7:0] a;
      begin
         if (a == `DBGEV_OFF_CTRL) begin
            dec = 3'h1;
         end else if (a == `DBGEV_OFF_STAT) begin
            dec = 3'h2;
         end else if (a == `DBGEV_OFF_EXT) begin
            dec = 3'h3;
         end else if (a == `DBGEV_OFF_SAVE) begin
            dec = 3'h4;
         end else if (a == `DBGEV_OFF_FETCH) begin
            dec = 3'h5;
         end else begin
            dec = 3'h0;
         end
      end
   endfunction

   // clear mask of a write-one-to-clear status register
   function [`DBGEV_STAT_W-1:0] clr_mask;
      input wr;
      input [31:0] d;
      begin
         if (wr) begin
            clr_mask = d[`DBGEV_STAT_W-1:0];
         end else begin
            clr_mask = {`DBGEV_STAT_W{1'b0}};
         end
      end
   endfunction

   // decoded register selects
   localparam [2:0] SEL_CTRL = 3'h1;
   localparam [2:0] SEL_STAT = 3'h2;
   localparam [2:0] SEL_EXT = 3'h3;
   localparam [2:0] SEL_SAVE = 3'h4;
   localparam [2:0] SEL_FETCH = 3'h5;

   wire [2:0] sel_setup = dec(paddr);
   wire acc_edge = psel & penable & pready;
   wire wr_edge = acc_edge & pwrite;
   wire wr_ctrl = wr_edge & (sel_setup == SEL_CTRL);
   wire wr_stat = wr_edge & (sel_setup == SEL_STAT);
   wire wr_ext = wr_edge & (sel_setup == SEL_EXT);

   // ==========================================================
   // effective enables for the retiring instruction
   // ==========================================================
   // mtspr sees its own new control value
   wire [`DBGEV_CTRL_W-1:0] ctl_eff =
      retire_ctl_wr ? retire_ctl_data : dbg_control0; // RULE7
   wire external_halt_mode = dbg_control0[`DBGEV_C_EXT_HALT];
   wire internal_dbg_mode = dbg_control0[`DBGEV_C_INT_MODE];
   wire edm_r = ctl_eff[`DBGEV_C_EXT_HALT];
   wire idm_r = ctl_eff[`DBGEV_C_INT_MODE];
   // mtmsr judged by its new allow; return by the old one
   wire de_r = retire_is_mtmsr ? dbg_irq_allow_after
                               : dbg_irq_allow; // RULE6 RULE8

   // ==========================================================
   // event conditions
   // ==========================================================
   // ==========================================================
   // instruction completion
   // ==========================================================
   wire instr_done_evt_cond = retire_valid & ctl_eff[`DBGEV_C_INSTR_DONE_EVT_EN] &
                    ~retire_suppressed & ~retire_saves_own_pc; // RULE1 RULE2
   wire instr_done_evt_ext = instr_done_evt_cond & edm_r; // RULE4
   wire instr_done_evt_int = instr_done_evt_cond & ~edm_r & idm_r & de_r; // RULE5
   // os call counts as done, save points at its handler
   wire [ADDR_W-1:0] instr_done_evt_pc = retire_is_os_call ? os_call_handler_addr
                                                 : retire_next_pc; // RULE3

   // ==========================================================
   // non-critical interrupt taken
   // ==========================================================
   wire irq_taken_evt_cond = irq_taken_valid & irq_is_noncrit &
                    dbg_control0[`DBGEV_C_IRQ_TAKEN_EVT_EN]; // RULE10
   wire irq_taken_evt_ext = irq_taken_evt_cond & external_halt_mode; // RULE11 RULE15
   wire irq_taken_evt_int_de = irq_taken_evt_cond & ~external_halt_mode & internal_dbg_mode & dbg_irq_allow; // RULE12
   wire irq_taken_evt_int_nd = irq_taken_evt_cond & ~external_halt_mode & internal_dbg_mode & ~dbg_irq_allow &
                      op_records_imprecise; // RULE13

   // ==========================================================
   // interrupt return
   // ==========================================================
   wire ret_cond = rfi_valid & ~rfi_higher_exc &
                   dbg_control0[`DBGEV_C_RET_EN]; // RULE16
   wire ret_ext = ret_cond & external_halt_mode; // RULE17 RULE15
   wire ret_int_de = ret_cond & ~external_halt_mode & internal_dbg_mode & dbg_irq_allow; // RULE18 RULE19
   wire ret_int_nd = ret_cond & ~external_halt_mode & internal_dbg_mode & ~dbg_irq_allow &
                     op_records_imprecise; // RULE19

   // ==========================================================
   // unconditional input
   // ==========================================================
   reg ude_prev_reg;
   wire ude_rise = unconditional_evt_input & ~ude_prev_reg;
   wire ude_cond = ude_rise & (external_halt_mode | internal_dbg_mode); // RULE20
   wire ude_ext = ude_cond & external_halt_mode; // RULE22
   wire ude_int = ude_cond & ~external_halt_mode; // RULE21 RULE23

   // ==========================================================
   // delayed interrupt
   // ==========================================================
   // delayed interrupt when allow is switched on with imprecise pending
   wire delayed = retire_valid & ~external_halt_mode & internal_dbg_mode & ~dbg_irq_allow &
                  dbg_irq_allow_after &
                  dbg_event_status[`DBGEV_S_IMPRECISE]; // RULE14

   // ==========================================================
   // status set terms
   // ==========================================================
   wire [`DBGEV_STAT_W-1:0] stat_set;
   wire [`DBGEV_STAT_W-1:0] ext_set;
   assign stat_set[`DBGEV_S_INSTR_DONE] = instr_done_evt_int;
   assign stat_set[`DBGEV_S_IRQ_TAKEN] = irq_taken_evt_int_de | irq_taken_evt_int_nd;
   assign stat_set[`DBGEV_S_IRQ_EXIT] = ret_int_de | ret_int_nd;
   assign stat_set[`DBGEV_S_UNCOND] = ude_int;
   assign stat_set[`DBGEV_S_IMPRECISE] =
      irq_taken_evt_int_nd | ret_int_nd | ude_int; // RULE13 RULE19 RULE23
   assign ext_set[`DBGEV_S_INSTR_DONE] = instr_done_evt_ext;
   assign ext_set[`DBGEV_S_IRQ_TAKEN] = irq_taken_evt_ext;
   assign ext_set[`DBGEV_S_IRQ_EXIT] = ret_ext;
   assign ext_set[`DBGEV_S_UNCOND] = ude_ext;
   assign ext_set[`DBGEV_S_IMPRECISE] = 1'b0;

   // ==========================================================
   // debug interrupt and halt selection
   // ==========================================================
   reg irq_next;
   reg [ADDR_W-1:0] save_next;
   reg halt_next;
   reg [ADDR_W-1:0] fetch_next;

   always @* begin
      irq_next = 1'b0;
      save_next = dbg_save_pc;
      if (irq_taken_evt_int_de) begin
         irq_next = 1'b1;
         save_next = irq_handler_addr; // RULE12
      end else if (ret_int_de) begin
         irq_next = 1'b1;
         save_next = rfi_pc; // RULE18
      end else if (instr_done_evt_int) begin
         irq_next = 1'b1;
         save_next = instr_done_evt_pc; // RULE9
      end else if (ude_int & dbg_irq_allow) begin
         irq_next = 1'b1;
         save_next = retire_next_pc; // RULE23
      end else if (delayed) begin
         irq_next = 1'b1;
         save_next = retire_next_pc; // RULE14
      end
   end

   always @* begin
      halt_next = 1'b0;
      fetch_next = next_fetch_addr;
      if (irq_taken_evt_ext) begin
         halt_next = 1'b1;
         fetch_next = irq_handler_addr; // RULE11
      end else if (ret_ext) begin
         halt_next = 1'b1;
         fetch_next = rfi_pc; // RULE17
      end else if (instr_done_evt_ext) begin
         halt_next = 1'b1;
         fetch_next = instr_done_evt_pc; // RULE4
      end else if (ude_ext) begin
         halt_next = 1'b1;
         fetch_next = retire_next_pc; // RULE22
      end
   end

   // ==========================================================
   // event state
   // ==========================================================
   // previous input level, idle low so reset makes no false edge
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ude_prev_reg <= 1'b0;
      end else begin
         ude_prev_reg <= unconditional_evt_input;
      end
   end

   // interrupt and halt pulses with their addresses
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dbg_irq <= 1'b0;
         dbg_save_pc <= {ADDR_W{1'b0}};
         halt_req <= 1'b0;
         next_fetch_addr <= {ADDR_W{1'b0}};
      end else begin
         dbg_irq <= irq_next;
         dbg_save_pc <= save_next;
         halt_req <= halt_next;
         next_fetch_addr <= fetch_next;
      end
   end

   // return must not execute when it halted or raised the debug interrupt
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         suppress_rfi <= 1'b0;
      end else begin
         suppress_rfi <= ret_ext | ret_int_de; // RULE17
      end
   end

   // control: pipeline mtspr wins over the bus
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dbg_control0 <= `DBGEV_CTRL_RST;
      end else if (retire_valid & retire_ctl_wr) begin
         dbg_control0 <= retire_ctl_data;
      end else if (wr_ctrl) begin
         dbg_control0 <= pwdata[`DBGEV_CTRL_W-1:0];
      end
   end

   // status: write one to clear, a new event wins
   wire [`DBGEV_STAT_W-1:0] stat_clr = clr_mask(wr_stat, pwdata);
   wire [`DBGEV_STAT_W-1:0] ext_clr = clr_mask(wr_ext, pwdata);
   localparam [`DBGEV_STAT_W-1:0] STAT_RST = `DBGEV_STAT_RST;
   genvar gi;

   generate
      for (gi = 0; gi < `DBGEV_STAT_W; gi = gi + 1) begin : g_stat
         always @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               dbg_event_status[gi] <= STAT_RST[gi];
               ext_dbg_event_status[gi] <= STAT_RST[gi];
            end else begin
               dbg_event_status[gi] <=
                  (dbg_event_status[gi] & ~stat_clr[gi]) | stat_set[gi];
               ext_dbg_event_status[gi] <=
                  (ext_dbg_event_status[gi] & ~ext_clr[gi]) | ext_set[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // apb answer: one wait-free access phase after setup
   // ==========================================================
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      if (sel_setup == SEL_CTRL) begin
         rd_mux[`DBGEV_CTRL_W-1:0] = dbg_control0;
      end else if (sel_setup == SEL_STAT) begin
         rd_mux[`DBGEV_STAT_W-1:0] = dbg_event_status;
      end else if (sel_setup == SEL_EXT) begin
         rd_mux[`DBGEV_STAT_W-1:0] = ext_dbg_event_status;
      end else if (sel_setup == SEL_SAVE) begin
         rd_mux = dbg_save_pc[31:0];
      end else if (sel_setup == SEL_FETCH) begin
         rd_mux = next_fetch_addr[31:0];
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (sel_setup == 3'h0);
         if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

endmodule // dbgev_recorder

`default_nettype wire

// file: tb/dbgev_checker.sv
// assertions on the debug event recorder ports
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_defines.vh"
module dbgev_checker #(parameter ADDR_W = 32) (
   // clock, reset, apb
   input wire logic core_clk, reset_n, psel, penable, pready,
   // pipeline and interrupt side
   input wire logic retire_valid, retire_suppressed, retire_saves_own_pc,
   input wire logic retire_is_os_call, retire_is_mtmsr, retire_ctl_wr,
   input wire logic dbg_irq_allow, dbg_irq_allow_after, irq_taken_valid,
   input wire logic irq_is_noncrit, rfi_valid, rfi_higher_exc,
   input wire logic unconditional_evt_input, dbg_irq, halt_req, suppress_rfi,
   input wire logic [ADDR_W-1:0] retire_next_pc, irq_handler_addr, rfi_pc,
   input wire logic [ADDR_W-1:0] dbg_save_pc, next_fetch_addr,
   input wire logic [`DBGEV_CTRL_W-1:0] dbg_control0,
   input wire logic [`DBGEV_STAT_W-1:0] dbg_event_status, ext_dbg_event_status
);
   // =====================
   // mode decode
   wire logic ext_m = dbg_control0[`DBGEV_C_EXT_HALT];
   wire logic int_m = dbg_control0[`DBGEV_C_INT_MODE] & ~ext_m;
   wire logic instr_done_evt = dbg_control0[`DBGEV_C_INSTR_DONE_EVT_EN];
   wire logic irq_taken_evt = dbg_control0[`DBGEV_C_IRQ_TAKEN_EVT_EN];
   wire logic ret = dbg_control0[`DBGEV_C_RET_EN];
   wire logic quiet = !irq_taken_valid && !rfi_valid && !retire_ctl_wr;
   wire logic clean = retire_valid && !retire_suppressed
      && !retire_saves_own_pc && !retire_is_os_call && quiet;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // =====================
   // properties
   ext_done_a: assert property (clean && ext_m && instr_done_evt |=> halt_req
      && ext_dbg_event_status[0] && next_fetch_addr == $past(retire_next_pc))
      else $error("external completion halt wrong");
   int_done_a: assert property (clean && int_m && instr_done_evt && dbg_irq_allow
      && !retire_is_mtmsr |=> dbg_irq && dbg_event_status[0]
      && dbg_save_pc == $past(retire_next_pc))
      else $error("internal completion interrupt wrong");
   no_suppress_a: assert property (retire_valid && dbg_irq_allow
      && (retire_suppressed || retire_saves_own_pc) && !retire_is_os_call
      && quiet && !unconditional_evt_input |=> !dbg_irq && !halt_req)
      else $error("suppressed instruction raised event");
   no_allow_a: assert property (clean && int_m && !dbg_irq_allow
      && !dbg_irq_allow_after && !unconditional_evt_input |=> !dbg_irq
      && dbg_event_status[0] <= $past(dbg_event_status[0]))
      else $error("completion recorded without allow");
   crit_irq_a: assert property (irq_taken_valid && !irq_is_noncrit
      && !retire_valid && !rfi_valid && !unconditional_evt_input
      |=> !dbg_irq && !halt_req) else $error("critical irq raised event");
   ext_irq_a: assert property (irq_taken_valid && irq_is_noncrit && ext_m
      && irq_taken_evt && !retire_ctl_wr |=> halt_req && ext_dbg_event_status[1]
      && next_fetch_addr == $past(irq_handler_addr))
      else $error("external irq taken halt wrong");
   ext_ret_a: assert property (rfi_valid && !rfi_higher_exc && ext_m && ret
      && !irq_taken_valid && !retire_ctl_wr |=> halt_req && suppress_rfi
      && ext_dbg_event_status[2] && next_fetch_addr == $past(rfi_pc))
      else $error("external return halt wrong");
   int_ret_a: assert property (rfi_valid && !rfi_higher_exc && int_m && ret
      && dbg_irq_allow && !irq_taken_valid && !retire_ctl_wr |=> dbg_irq
      && dbg_event_status[2] && dbg_save_pc == $past(rfi_pc))
      else $error("internal return interrupt wrong");
   int_uncond_a: assert property ($rose(unconditional_evt_input) && int_m
      && !retire_ctl_wr |=> dbg_event_status[3] && dbg_event_status[4])
      else $error("unconditional event not recorded");
   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb ready timing wrong");
endmodule // dbgev_checker
bind dbgev_recorder dbgev_checker #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire

// file: tb/dbgev_ext_ctrl.sv
// model of the external debug controller driving the unconditional input
`timescale 1ns/1ps
`default_nettype none
module dbgev_ext_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // request in, event line out
   input wire logic go,
   output logic uevt
);
   logic [1:0] cnt_reg;
   // high three cycles, low between events
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         uevt <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (go) begin
         uevt <= 1'b1;
         cnt_reg <= 2'h2;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end else begin
         uevt <= 1'b0;
      end
   end
endmodule // dbgev_ext_ctrl
`default_nettype wire

// file: tb/debug_event_recorder_tb.sv
// self-checking bench of the debug event recorder
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_defines.vh"
module debug_event_recorder_tb;
   logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic ug = 0, dbg_irq_allow = 0, dbg_irq_allow_after = 0;
   logic op_records_imprecise = 0, pready, pslverr, dbg_irq, halt_req;
   logic suppress_rfi, unconditional_evt_input;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, retire_next_pc = 0, irq_handler_addr = 0;
   logic [31:0] rfi_pc = 0, os_call_handler_addr = 0;
   logic [31:0] prdata, dbg_save_pc, next_fetch_addr;
   logic [4:0] dbg_control0, dbg_event_status, ext_dbg_event_status;
   logic [8:0] kv = 0;
   logic [5:0] cv = 0;
   logic [34:0] q[$];
   int n_mismatch = 0, compares = 0, i;
   dbgev_recorder uut (.*, .retire_valid(kv[0]), .retire_suppressed(kv[1]),
      .retire_saves_own_pc(kv[2]), .retire_is_os_call(kv[3]),
      .retire_is_mtmsr(kv[4]), .irq_taken_valid(kv[5]),
      .irq_is_noncrit(kv[6]), .rfi_valid(kv[7]), .rfi_higher_exc(kv[8]),
      .retire_ctl_wr(cv[5]), .retire_ctl_data(cv[4:0]));
   dbgev_ext_ctrl ext_i (.core_clk, .reset_n, .go(ug),
      .uevt(unconditional_evt_input));
   initial forever #10 core_clk = ~core_clk;
   // =====================
   // tasks
   task stop_test;
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [34:0] s, e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task ex(input logic [2:0] f, input logic [31:0] v);
      q.push_back({f, v});
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v, input logic e);
      ex({2'b00, e}, v);
      apb(0, a, 0);
   endtask
   task wc(input logic [31:0] d);
      apb(1, `DBGEV_OFF_CTRL, d);
      apb(1, `DBGEV_OFF_STAT, 32'h1F);
   endtask
   task go(input logic [8:0] k, input logic a, b, input logic [5:0] c);
      @(posedge core_clk);
      kv <= k;
      cv <= c;
      dbg_irq_allow <= a;
      dbg_irq_allow_after <= b;
      retire_next_pc <= $urandom;
      irq_handler_addr <= $urandom;
      rfi_pc <= $urandom;
      os_call_handler_addr <= $urandom;
      @(posedge core_clk);
      kv <= 0;
      cv <= 0;
   endtask
   task ud;
      @(posedge core_clk);
      ug <= 1;
      @(posedge core_clk);
      ug <= 0;
      repeat (6) @(posedge core_clk);
   endtask
   // =====================
   // result monitor and watchdog
   always @(negedge core_clk)
      if (reset_n && (dbg_irq || halt_req || (pready && !pwrite))) begin
         if (q.size() == 0) chk(35'h1, 35'h0);
         else chk({dbg_irq, halt_req, pslverr, dbg_irq ? dbg_save_pc :
            halt_req ? next_fetch_addr : prdata}, q.pop_front());
      end
   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end
   // =====================
   // scenarios
   initial begin
      i = $urandom(32'hF5DA187D);
      repeat (5) @(posedge core_clk);
      reset_n <= 1;
      rd(`DBGEV_OFF_CTRL, 0, 0);
      rd(8'h14, 0, 1);
      wc(32'h06);
      rd(`DBGEV_OFF_CTRL, 32'h06, 0);
      for (i = 0; i < 2; i++) begin
         go(9'h001, 1, 1, 0);
         ex(3'b100, retire_next_pc);
      end
      go(9'h003, 1, 1, 0);
      go(9'h005, 1, 1, 0);
      go(9'h009, 1, 1, 0);
      ex(3'b100, os_call_handler_addr);
      go(9'h001, 0, 0, 0);
      go(9'h011, 0, 1, 0);
      ex(3'b100, retire_next_pc);
      go(9'h011, 1, 0, 0);
      wc(32'h02);
      go(9'h001, 1, 1, 6'h26);
      ex(3'b100, retire_next_pc);
      go(9'h001, 1, 1, 6'h22);
      wc(32'h0A);
      go(9'h060, 1, 1, 0);
      ex(3'b100, irq_handler_addr);
      go(9'h020, 1, 1, 0);
      op_records_imprecise <= 1;
      go(9'h060, 0, 0, 0);
      rd(`DBGEV_OFF_STAT, 32'h12, 0);
      go(9'h011, 0, 1, 0);
      ex(3'b100, retire_next_pc);
      wc(32'h12);
      go(9'h080, 1, 1, 0);
      ex(3'b100, rfi_pc);
      go(9'h180, 1, 1, 0);
      go(9'h080, 0, 0, 0);
      rd(`DBGEV_OFF_STAT, 32'h14, 0);
      wc(32'h02);
      go(0, 1, 1, 0);
      ex(3'b100, retire_next_pc);
      ud;
      go(0, 0, 0, 0);
      ud;
      rd(`DBGEV_OFF_STAT, 32'h18, 0);
      wc(32'h1D);
      go(9'h001, 0, 0, 0);
      ex(3'b010, retire_next_pc);
      go(9'h060, 0, 0, 0);
      ex(3'b010, irq_handler_addr);
      go(9'h080, 0, 0, 0);
      ex(3'b010, rfi_pc);
      ex(3'b010, retire_next_pc);
      ud;
      rd(`DBGEV_OFF_EXT, 32'h0F, 0);
      repeat (5) @(posedge core_clk);
      chk(35'(q.size()), 0);
      stop_test;
   end
endmodule // debug_event_recorder_tb
`default_nettype wire
